//--- testbench/ldmc_lcd_panel.sv
`timescale 1ns/1ps
`default_nettype none
module ldmc_lcd_panel (
   input  wire logic        mclk,
   input  wire logic [15:0] lcdData,
   output logic      [15:0] shownPix
);
   // panel latches every cycle, blanked or not
   always_ff @(posedge mclk) begin
      shownPix <= lcdData;
   end
endmodule // ldmc_lcd_panel
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ldmc_pkg::*;
   logic        mclk, rst, psel, penable, pwrite, rotLowBit, singlePanel, activeMatrix;
   logic        pready, pslverr, pipeEnable, lutBypass, dualBufEnable, depthValid, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   logic [15:0] rawPixel, lutPixel, lcdData, shownPix;
   ldmc_rot_t   rotation;
   logic [2:0]  depthBpp;
   int          n_fail, tests_run;
   ldmc_display_mode ldmc_display_mode_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .rotLowBit, .singlePanel, .activeMatrix, .rawPixel, .lutPixel,
      .lcdData, .pipeEnable, .lutBypass, .dualBufEnable, .rotation, .depthBpp, .depthValid);
   ldmc_lcd_panel ldmc_lcd_panel_i (.mclk, .lcdData, .shownPix);
   // ==========
   // helpers
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic apb(logic wr, logic [11:0] a, logic [31:0] d, logic [3:0] s);
      int k;
      k = 0;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) n_fail++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge mclk);
   endtask
   task automatic pix(logic [15:0] raw, logic [15:0] lut, logic [15:0] exp);
      @(posedge mclk);
      rawPixel <= raw;
      lutPixel <= lut;
      @(posedge mclk);
      @(negedge mclk);
      chk("lcdData", lcdData, exp);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // ==========
   // scenarios
   task automatic t_regs();
      apb(0, LDMC_ADDR_DISPLAY_MODE, 0, 0);
      chk("mode rst", rd, 0);
      chk("pipe rst", pipeEnable, 1);
      chk("dual rst", dualBufEnable, 1);
      apb(1, LDMC_ADDR_DISPLAY_MODE, 32'hFF, 4'h1);
      apb(1, LDMC_ADDR_DISPLAY_MODE, 0, 4'h0);
      apb(0, LDMC_ADDR_DISPLAY_MODE, 0, 0);
      chk("mode", rd, 32'h97);
      apb(1, LDMC_ADDR_MISC_CONTROL, 32'hFF, 4'h1);
      apb(0, LDMC_ADDR_MISC_CONTROL, 0, 0);
      chk("misc", rd, 32'h03);
      apb(1, 12'h0FC, 32'hFF, 4'h1);
      chk("err", err, 1);
      apb(1, LDMC_ADDR_MISC_CONTROL, 0, 4'h1);
   endtask
   task automatic t_blank();
      apb(1, LDMC_ADDR_DISPLAY_MODE, 32'h85, 4'h1);
      chk("pipe", pipeEnable, 0);
      pix(16'hABCD, 16'h1234, 16'h0000);
      chk("panel", shownPix, 0);
      apb(1, LDMC_ADDR_DISPLAY_MODE, 32'h05, 4'h1);
      chk("pipe", pipeEnable, 1);
      pix(16'hABCD, 16'h1234, 16'hABCD);
   endtask
   task automatic t_rot();
      ldmc_rot_t e[4] = '{LDMC_ROT_0, LDMC_ROT_90, LDMC_ROT_180, LDMC_ROT_270};
      for (int i = 0; i < 4; i++) begin
         @(posedge mclk);
         rotLowBit <= i[0];
         apb(1, LDMC_ADDR_DISPLAY_MODE, {27'h0, i[1], 4'h5}, 4'h1);
         chk("rotation", rotation, e[i]);
         apb(0, LDMC_ADDR_PIPE_STATUS, 0, 0);
         chk("status", rd, {26'h0, 4'hF, i == 2, i == 1});
      end
   endtask
   task automatic t_depth();
      for (int c = 0; c < 8; c++) begin
         apb(1, LDMC_ADDR_DISPLAY_MODE, c, 4'h1);
         chk("depth", depthBpp, c[2:0]);
         chk("valid", depthValid, c == 2 || c == 3 || c == 5);
         chk("bypass", lutBypass, c == 5);
         pix(16'hABCD, 16'h1234, c == 5 ? 16'hABCD : 16'h1234);
      end
   endtask
   task automatic t_dith();
      apb(1, LDMC_ADDR_DISPLAY_MODE, 32'h05, 4'h1);
      apb(1, LDMC_ADDR_MISC_CONTROL, 32'h02, 4'h1);
      pix(16'hFFFF, 16'h1234, 16'hF79E);
      @(posedge mclk);
      activeMatrix <= 1'b1;
      pix(16'hFFFF, 16'h1234, 16'hFFFF);
      @(posedge mclk);
      activeMatrix <= 1'b0;
      apb(1, LDMC_ADDR_DISPLAY_MODE, 32'h03, 4'h1);
      pix(16'hFFFF, 16'h1234, 16'h1234);
      apb(1, LDMC_ADDR_MISC_CONTROL, 32'h01, 4'h1);
      chk("dual", dualBufEnable, 0);
      apb(1, LDMC_ADDR_DISPLAY_MODE, 32'h85, 4'h1);
      pix(16'hFFFF, 16'h1234, 16'h0000);
      @(posedge mclk);
      singlePanel <= 1'b1;
      apb(1, LDMC_ADDR_MISC_CONTROL, 0, 4'h1);
      chk("dual", dualBufEnable, 0);
   endtask
   initial begin
      mclk = 0;
      forever #12.5 mclk = ~mclk;
   end
   initial begin
      {rst, psel, penable, pwrite, rotLowBit, singlePanel, activeMatrix} = 7'b1000000;
      {paddr, pwdata, pstrb, rawPixel, lutPixel} = '0;
      {n_fail, tests_run} = 0;
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      t_regs();
      t_blank();
      t_rot();
      t_depth();
      t_dith();
      wrap_up();
   end
   // hang guard, far beyond the 150 or so cycles needed
   initial begin
      #200000;
      n_fail++;
      wrap_up();
   end
endmodule // tb_top
`default_nettype wire

//--- verilog/ldmc_display_mode.sv
// Functional notes
// - blank bit set stops pipeline and forces all lcd data to zero.
// - upper rotation bit set rotates image 180 degrees.
// - rotation bits decode to 0, 90, 180, 270 degrees; lower bit external.
// - depth codes 010=4, 011=8, 101=16 bpp; others reserved.
// - 16 bpp bypasses the colour lookup table.
// - dither disable limits passive 16 bpp to 4096 colours.
// - active-matrix panels get up to 64K colours.
// - dual buffer disable bit turns the dual panel buffer off.
// - single panel forces buffer off, disable bit ignored.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module ldmc_display_mode (
   input  wire logic                            mclk,
   input  wire logic                            rst,
   input  wire logic                            psel,
   input  wire logic                            penable,
   input  wire logic                            pwrite,
   input  wire logic [11:0]                     paddr,
   input  wire logic [31:0]                     pwdata,
   input  wire logic [3:0]                      pstrb,
   output logic      [31:0]                     prdata,
   output logic                                 pready,
   output logic                                 pslverr,
   input  wire logic                            rotLowBit,
   input  wire logic                            singlePanel,
   input  wire logic                            activeMatrix,
   input  wire logic [ldmc_pkg::LDMC_PIX_W-1:0] rawPixel,
   input  wire logic [ldmc_pkg::LDMC_PIX_W-1:0] lutPixel,
   output logic      [ldmc_pkg::LDMC_PIX_W-1:0] lcdData,
   output logic                                 pipeEnable,
   output logic                                 lutBypass,
   output logic                                 dualBufEnable,
   output ldmc_pkg::ldmc_rot_t                  rotation,
   output logic      [2:0]                      depthBpp,
   output logic                                 depthValid
);
   import ldmc_pkg::*;

   // ===================================================
   // apb slave
   logic [7:0] modeReg;
   logic [7:0] miscReg;
   logic       wrEn;
   logic       rdEn;
   logic       hitMode;
   logic       hitMisc;
   logic       hitStat;

   assign hitMode = (paddr == LDMC_ADDR_DISPLAY_MODE);
   assign hitMisc = (paddr == LDMC_ADDR_MISC_CONTROL);
   assign hitStat = (paddr == LDMC_ADDR_PIPE_STATUS);
   assign wrEn    = psel && penable && pwrite && pstrb[0];
   assign rdEn    = psel && penable && !pwrite;
   // zero wait states keeps the bus simple
   assign pready  = 1'b1;
   assign pslverr = psel && penable && !(hitMode || hitMisc || hitStat);

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         modeReg <= LDMC_RST_DISPLAY_MODE;
      end else if (wrEn && hitMode) begin
         modeReg <= pwdata[7:0] & LDMC_MASK_DISPLAY_MODE;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         miscReg <= LDMC_RST_MISC_CONTROL;
      end else if (wrEn && hitMisc) begin
         miscReg <= pwdata[7:0] & LDMC_MASK_MISC_CONTROL;
      end
   end

   always_comb begin
      prdata = 32'h0000_0000;
      if (rdEn && hitMode) begin
         prdata = {24'h00_0000, modeReg};
      end else if (rdEn && hitMisc) begin
         prdata = {24'h00_0000, miscReg};
      end else if (rdEn && hitStat) begin
         prdata = {26'h000_0000, depthValid, lutBypass, dualBufEnable, pipeEnable, rotation[2], rotation[1]};
      end
   end

   // ===================================================
   // mode decode
   logic blank;
   assign blank      = modeReg[LDMC_BIT_BLANK];
   assign pipeEnable = !blank;
   assign depthBpp   = modeReg[2:0];

   always_comb begin
      unique case (depthBpp)
         LDMC_BPP_4, LDMC_BPP_8, LDMC_BPP_16: depthValid = 1'b1;
         default: depthValid = 1'b0;
      endcase
   end

   always_comb begin
      unique case ({modeReg[LDMC_BIT_ROT_HI], rotLowBit})
         2'b00: rotation = LDMC_ROT_0;
         2'b01: rotation = LDMC_ROT_90;
         2'b10: rotation = LDMC_ROT_180;
         2'b11: rotation = LDMC_ROT_270;
      endcase
   end

   // single panel always wins over the software bit
   assign dualBufEnable = !singlePanel && !miscReg[LDMC_BIT_DPB_DIS];

   // ===================================================
   // pixel output
   ldmc_pixel_path u_path (
      .mclk          (mclk),
      .rst           (rst),
      .blank         (blank),
      .bppSel        (depthBpp),
      .ditherDisable (miscReg[LDMC_BIT_DITH_DIS]),
      .activeMatrix  (activeMatrix),
      .rawPixel      (rawPixel),
      .lutPixel      (lutPixel),
      .lcdData       (lcdData),
      .lutBypass     (lutBypass)
   );

   // ===================================================
   // bus side checks
   // refused writes must leave both registers alone
   a_write_takes: assert property (@(posedge mclk) disable iff (rst)
      wrEn && hitMode
      |=> modeReg == $past(pwdata[7:0] & LDMC_MASK_DISPLAY_MODE))
      else $error("write lost");

   a_misc_takes: assert property (@(posedge mclk) disable iff (rst)
      wrEn && hitMisc
      |=> miscReg == $past(pwdata[7:0] & LDMC_MASK_MISC_CONTROL))
      else $error("misc write lost");

   a_strb_gate: assert property (@(posedge mclk) disable iff (rst)
      psel && penable && pwrite && !pstrb[0]
      |=> $stable(modeReg) && $stable(miscReg))
      else $error("write without strobe landed");

   a_read_keeps: assert property (@(posedge mclk) disable iff (rst)
      rdEn
      |=> $stable(modeReg) && $stable(miscReg))
      else $error("read changed a register");

   a_err_keeps: assert property (@(posedge mclk) disable iff (rst)
      psel && penable && pwrite && pslverr
      |=> $stable(modeReg) && $stable(miscReg))
      else $error("refused write landed");

   a_err_setup: assert property (@(posedge mclk) disable iff (rst)
      psel && !penable
      |-> !pslverr)
      else $error("error outside access phase");

   a_err_mapped: assert property (@(posedge mclk) disable iff (rst)
      psel && penable && (hitMode || hitMisc || hitStat)
      |-> !pslverr)
      else $error("error on mapped register");

   a_err_unaligned: assert property (@(posedge mclk) disable iff (rst)
      psel && penable && paddr[1:0] != 2'b00
      |-> pslverr)
      else $error("unaligned access accepted");

   a_rdata_idle: assert property (@(posedge mclk) disable iff (rst)
      !(psel && penable)
      |-> prdata == 32'h0000_0000)
      else $error("read data outside access");

   a_rdata_mode: assert property (@(posedge mclk) disable iff (rst)
      rdEn && hitMode
      |-> prdata == {24'h00_0000, modeReg})
      else $error("mode read data wrong");

   a_rdata_misc: assert property (@(posedge mclk) disable iff (rst)
      rdEn && hitMisc
      |-> prdata == {24'h00_0000, miscReg})
      else $error("misc read data wrong");

   a_mode_masked: assert property (@(posedge mclk) disable iff (rst)
      $changed(modeReg)
      |-> (modeReg & ~LDMC_MASK_DISPLAY_MODE) == 8'h00)
      else $error("unused mode bit set");

   a_misc_masked: assert property (@(posedge mclk) disable iff (rst)
      $changed(miscReg)
      |-> (miscReg & ~LDMC_MASK_MISC_CONTROL) == 8'h00)
      else $error("unused misc bit set");

   // ===================================================
   // blanking checks
   // blank acts one cycle late on the registered data
   a_blank_zero: assert property (@(posedge mclk) disable iff (rst)
      $past(blank)
      |-> lcdData == '0)
      else $error("lcd data not zero while blanked");

   a_pipe_off: assert property (@(posedge mclk) disable iff (rst)
      blank
      |-> !pipeEnable)
      else $error("pipeline running while blanked");

   a_pipe_run: assert property (@(posedge mclk) disable iff (rst)
      !blank
      |-> pipeEnable)
      else $error("pipeline stopped while not blanked");

   // ===================================================
   // depth checks
   // reserved codes fall back to the lut path
   a_depth_code: assert property (@(posedge mclk) disable iff (rst)
      depthBpp == 3'h4
      |-> !depthValid)
      else $error("reserved depth accepted");

   a_depth_4: assert property (@(posedge mclk) disable iff (rst)
      depthBpp == LDMC_BPP_4
      |-> depthValid)
      else $error("4 bpp refused");

   a_depth_8: assert property (@(posedge mclk) disable iff (rst)
      depthBpp == LDMC_BPP_8
      |-> depthValid)
      else $error("8 bpp refused");

   a_depth_16: assert property (@(posedge mclk) disable iff (rst)
      depthBpp == LDMC_BPP_16
      |-> depthValid)
      else $error("16 bpp refused");

   a_depth_res_lo: assert property (@(posedge mclk) disable iff (rst)
      depthBpp < 3'h2
      |-> !depthValid)
      else $error("low reserved depth accepted");

   a_depth_res_hi: assert property (@(posedge mclk) disable iff (rst)
      depthBpp > 3'h5
      |-> !depthValid)
      else $error("high reserved depth accepted");

   a_lut_bypass: assert property (@(posedge mclk) disable iff (rst)
      depthBpp == LDMC_BPP_16
      |-> lutBypass)
      else $error("lut bypass wrong");

   // ===================================================
   // rotation checks
   // lower bit arrives as a level from elsewhere
   a_rot_half: assert property (@(posedge mclk) disable iff (rst)
      modeReg[LDMC_BIT_ROT_HI] && !rotLowBit
      |-> rotation == LDMC_ROT_180)
      else $error("180 rotation wrong");

   a_rot_decode: assert property (@(posedge mclk) disable iff (rst)
      rotLowBit && !modeReg[LDMC_BIT_ROT_HI]
      |-> rotation == LDMC_ROT_90)
      else $error("90 rotation wrong");

   a_rot_none: assert property (@(posedge mclk) disable iff (rst)
      !rotLowBit && !modeReg[LDMC_BIT_ROT_HI]
      |-> rotation == LDMC_ROT_0)
      else $error("normal rotation wrong");

   a_rot_full: assert property (@(posedge mclk) disable iff (rst)
      rotLowBit && modeReg[LDMC_BIT_ROT_HI]
      |-> rotation == LDMC_ROT_270)
      else $error("270 rotation wrong");

   a_rot_onehot: assert property (@(posedge mclk) disable iff (rst)
      $changed(rotation)
      |-> $onehot(rotation))
      else $error("rotation not one-hot");

   // ===================================================
   // pixel data checks
   // dither cut keeps 4 bits of each primary
   a_lut_path: assert property (@(posedge mclk) disable iff (rst)
      !blank && !lutBypass
      |=> lcdData == $past(lutPixel))
      else $error("lut pixel not passed");

   a_dither_cut: assert property (@(posedge mclk) disable iff (rst)
      !blank && lutBypass && miscReg[LDMC_BIT_DITH_DIS] && !activeMatrix
      |=> lcdData[11] == 1'b0 && lcdData[0] == 1'b0)
      else $error("4096 colour limit missed");

   a_dither_green: assert property (@(posedge mclk) disable iff (rst)
      !blank && lutBypass && miscReg[LDMC_BIT_DITH_DIS] && !activeMatrix
      |=> lcdData[6:5] == 2'b00)
      else $error("green not cut to 4 bits");

   a_dither_keep: assert property (@(posedge mclk) disable iff (rst)
      !blank && lutBypass && miscReg[LDMC_BIT_DITH_DIS] && !activeMatrix
      |=> lcdData[15:12] == $past(rawPixel[15:12]) && lcdData[10:7] == $past(rawPixel[10:7]))
      else $error("upper colour bits lost");

   a_dither_off: assert property (@(posedge mclk) disable iff (rst)
      !blank && lutBypass && !miscReg[LDMC_BIT_DITH_DIS]
      |=> lcdData == $past(rawPixel))
      else $error("full colour cut with dither on");

   a_active_full: assert property (@(posedge mclk) disable iff (rst)
      !blank && lutBypass && activeMatrix
      |=> lcdData == $past(rawPixel))
      else $error("tft depth cut");

   a_dither_other: assert property (@(posedge mclk) disable iff (rst)
      !blank && !lutBypass && miscReg[LDMC_BIT_DITH_DIS]
      |=> lcdData == $past(lutPixel))
      else $error("dither disable hit other depth");

   a_dither_active: assert property (@(posedge mclk) disable iff (rst)
      !blank && lutBypass && activeMatrix && miscReg[LDMC_BIT_DITH_DIS]
      |=> lcdData == $past(rawPixel))
      else $error("dither disable hit active panel");

   // ===================================================
   // dual buffer checks
   // single panel overrides the software bit
   a_dpb_off: assert property (@(posedge mclk) disable iff (rst)
      miscReg[LDMC_BIT_DPB_DIS]
      |-> !dualBufEnable)
      else $error("dual buffer not off");

   a_single_panel: assert property (@(posedge mclk) disable iff (rst)
      singlePanel
      |-> !dualBufEnable)
      else $error("single panel buffer on");

   a_dpb_on: assert property (@(posedge mclk) disable iff (rst)
      !singlePanel && !miscReg[LDMC_BIT_DPB_DIS]
      |-> dualBufEnable)
      else $error("dual buffer not on");

endmodule // ldmc_display_mode
`default_nettype wire

//--- verilog/ldmc_pixel_path.sv
`timescale 1ns/1ps
`default_nettype none
module ldmc_pixel_path (
   input  wire logic                           mclk,
   input  wire logic                           rst,
   input  wire logic                           blank,
   input  wire logic [2:0]                     bppSel,
   input  wire logic                           ditherDisable,
   input  wire logic                           activeMatrix,
   input  wire logic [ldmc_pkg::LDMC_PIX_W-1:0] rawPixel,
   input  wire logic [ldmc_pkg::LDMC_PIX_W-1:0] lutPixel,
   output logic      [ldmc_pkg::LDMC_PIX_W-1:0] lcdData,
   output logic                                lutBypass
);
   import ldmc_pkg::*;
   logic                  is16;
   logic                  reduce;
   logic [LDMC_PIX_W-1:0] next_data;

   assign is16      = (bppSel == LDMC_BPP_16);
   assign lutBypass = is16;
   // dither only matters for passive 16 bpp
   assign reduce    = is16 && ditherDisable && !activeMatrix;

   always_comb begin
      if (!is16) begin
         next_data = lutPixel;
      end else if (reduce) begin
         // 4 bits per primary: 4096 colours
         next_data = {rawPixel[15:12], 1'b0, rawPixel[10:7], 2'b00, rawPixel[4:1], 1'b0};
      end else begin
         next_data = rawPixel;
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         lcdData <= '0;
      end else if (blank) begin
         lcdData <= '0;
      end else begin
         lcdData <= next_data;
      end
   end
endmodule // ldmc_pixel_path
`default_nettype wire

//--- verilog/ldmc_pkg.sv
`default_nettype none
package ldmc_pkg;
   // =====================================================
   // register map: word index, byte address is four times the index
   localparam logic [9:0]  LDMC_IDX_DISPLAY_MODE  = 10'h040;
   localparam logic [9:0]  LDMC_IDX_MISC_CONTROL  = 10'h041;
   localparam logic [9:0]  LDMC_IDX_PIPE_STATUS   = 10'h080;
   localparam logic [11:0] LDMC_ADDR_DISPLAY_MODE = {LDMC_IDX_DISPLAY_MODE, 2'b00};
   localparam logic [11:0] LDMC_ADDR_MISC_CONTROL = {LDMC_IDX_MISC_CONTROL, 2'b00};
   localparam logic [11:0] LDMC_ADDR_PIPE_STATUS  = {LDMC_IDX_PIPE_STATUS, 2'b00};
   // =====================================================
   // field positions
   localparam int LDMC_BIT_BLANK     = 7;
   localparam int LDMC_BIT_ROT_HI    = 4;
   localparam int LDMC_BIT_DITH_DIS  = 1;
   localparam int LDMC_BIT_DPB_DIS   = 0;
   // =====================================================
   // reset values and write masks
   localparam logic [7:0] LDMC_RST_DISPLAY_MODE = 8'h00;
   localparam logic [7:0] LDMC_RST_MISC_CONTROL = 8'h00;
   localparam logic [7:0] LDMC_MASK_DISPLAY_MODE = 8'h97;
   localparam logic [7:0] LDMC_MASK_MISC_CONTROL = 8'h03;
   // =====================================================
   // colour depth codes
   localparam logic [2:0] LDMC_BPP_4  = 3'h2;
   localparam logic [2:0] LDMC_BPP_8  = 3'h3;
   localparam logic [2:0] LDMC_BPP_16 = 3'h5;
   localparam int         LDMC_PIX_W  = 16;
   typedef enum logic [3:0] {
      LDMC_ROT_0   = 4'h1,
      LDMC_ROT_90  = 4'h2,
      LDMC_ROT_180 = 4'h4,
      LDMC_ROT_270 = 4'h8
   } ldmc_rot_t;
endpackage
`default_nettype wire
